//--- rtl/sdlm_pkg.sv
/*
 * Shared constants for the byte-lane data path: burst shape, register map,
 * configuration bit positions, reset values and link-side state encodings.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sdlm_pkg;

    // ==========================================================
    // Burst shape
    localparam int         BEATS      = 8;
    localparam int         BYTE_W     = 8;
    localparam logic [3:0] ZERO_LIMIT = 4'h4;
    localparam logic [2:0] LAST_BEAT  = 3'h7;

    // ==========================================================
    // Register map
    localparam logic [7:0] CFG_OFS  = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;

    localparam int CFG_W        = 7;
    localparam int CFG_MASK_BIT = 0;
    localparam int CFG_WINV_BIT = 1;
    localparam int CFG_RINV_BIT = 2;
    localparam int CFG_TERM_BIT = 3;
    localparam int CFG_CRC_BIT  = 4;
    localparam int CFG_WPRE_BIT = 5;
    localparam int CFG_RPRE_BIT = 6;

    localparam logic [CFG_W-1:0] CFG_RST = 7'h00;
    localparam logic [7:0]       CNT_RST = 8'h00;
    // Core clocks of link reset stretch; spans four slow link clocks
    localparam logic [4:0]       LRST_HOLD = 5'h1f;

    // ==========================================================
    // Preamble lengths in link clocks
    localparam logic [1:0] PRE_1CK = 2'h1;
    localparam logic [1:0] PRE_2CK = 2'h2;

    // ==========================================================
    // Link-side state machines
    typedef enum logic [1:0] {
        LW_IDLE = 2'b00,
        LW_PRE  = 2'b01,
        LW_DATA = 2'b10,
        LW_CRC  = 2'b11
    } sdlm_lw_e;

    typedef enum logic [1:0] {
        LR_IDLE = 2'b00,
        LR_PRE  = 2'b01,
        LR_DATA = 2'b10
    } sdlm_lr_e;

endpackage

//--- rtl/sdlm_lane.sv
/*
 * One byte lane for one beat: write-side inversion and mask decode, and
 * read-side zero-count inversion. Purely combinational.
 * Assumes the enables are already reduced to legal combinations.
 */
`timescale 1ns/10ps
module sdlm_lane
    import sdlm_pkg::*;
(
    input  wire logic [BYTE_W-1:0] wr_byte,   // Byte as received
    input  wire logic              wr_flag,   // Shared lane pin, active low
    input  wire logic              mask_en,   // Mask function on
    input  wire logic              wr_inv_en, // Write inversion on
    input  wire logic              rd_inv_en, // Read inversion on
    input  wire logic [BYTE_W-1:0] rd_byte,   // Byte from the array
    output logic      [BYTE_W-1:0] wr_store,  // Byte to store
    output logic                   wr_keep,   // Byte enable for the array
    output logic      [BYTE_W-1:0] rd_drive,  // Byte to drive out
    output logic                   rd_flag    // Lane inversion flag out
);

    logic [3:0] zeros;

    always_comb
    begin
        wr_store = wr_byte;
        wr_keep  = 1'b1;
        if (wr_inv_en)
        begin
            wr_store = wr_flag ? wr_byte : ~wr_byte;
        end
        else if (mask_en)
        begin
            wr_keep = wr_flag;
        end
        zeros = 4'h0;
        for (int i = 0; i < BYTE_W; i++)
        begin
            zeros = zeros + {3'h0, ~rd_byte[i]};
        end
        if (rd_inv_en && (zeros > ZERO_LIMIT))
        begin
            rd_drive = ~rd_byte;
            rd_flag  = 1'b0;
        end
        else
        begin
            rd_drive = rd_byte;
            rd_flag  = 1'b1;
        end
    end

endmodule

//--- rtl/sdlm_top.sv
/*
 * Byte-lane data path of a DDR memory die: captures write bursts on the
 * link clock, applies inversion (sixteen-bit part only), masking and write-check policy, commits
 * to the array port; encodes read bursts and drives them on the link.
 * Assumes the controller keeps legal mode combinations and burst spacing.
 */
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
module sdlm_top
    import sdlm_pkg::*;
#(
    parameter bit WIDE = 1'b1
)(
    input  wire logic                            sys_clk,       // Core clock
    input  wire logic                            rst_b,         // Sync reset, low
    input  wire logic                            ce,            // Clock enable
    input  wire logic [7:0]                      reg_addr,      // Register address
    input  wire logic [31:0]                     reg_wdata,     // Register write data
    input  wire logic                            reg_wr,        // Write strobe
    input  wire logic                            reg_rd,        // Read strobe
    output logic      [31:0]                     reg_rdata,     // Read data, next cycle
    input  wire logic                            link_clk,      // Link clock
    input  wire logic                            link_wr_start, // Write burst start
    input  wire logic [(WIDE ? 16 : 8)-1:0]      link_dq_in,    // Data pins in
    input  wire logic [(WIDE ? 2 : 1)-1:0]       link_flag_in,  // Lane pins in
    input  wire logic                            link_crc_ok,   // Write check result
    output logic      [(WIDE ? 16 : 8)-1:0]      link_dq_out,   // Data pins out
    output logic                                 link_dq_oe,    // Data pins driven
    output logic      [(WIDE ? 2 : 1)-1:0]       link_flag_out, // Lane pins out
    output logic                                 link_flag_oe,  // Lane pins driven
    input  wire logic                            rd_req,        // Read burst request
    input  wire logic [BEATS*(WIDE ? 16 : 8)-1:0] rd_data,      // Read burst data
    output logic                                 array_we,      // Array write pulse
    output logic      [BEATS*(WIDE ? 16 : 8)-1:0] array_data,   // Array write data
    output logic      [BEATS*(WIDE ? 2 : 1)-1:0] array_be       // Array byte enables
);

    localparam int LANES = WIDE ? 2 : 1;
    localparam int DQW   = LANES * BYTE_W;
    localparam int BW    = BEATS * DQW;
    localparam int FW    = BEATS * LANES;

    // ==========================================================
    // Configuration view, illegal combinations reduced
    logic [CFG_W-1:0] cfg_reg, cfg_next;
    logic             mask_eff, winv_eff, rinv_eff, crc_en;

    assign mask_eff = cfg_reg[CFG_MASK_BIT] & ~cfg_reg[CFG_TERM_BIT];
    assign winv_eff = WIDE & cfg_reg[CFG_WINV_BIT] & ~cfg_reg[CFG_MASK_BIT]
                      & ~cfg_reg[CFG_TERM_BIT];
    assign rinv_eff = WIDE & cfg_reg[CFG_RINV_BIT] & ~cfg_reg[CFG_TERM_BIT];
    assign crc_en   = cfg_reg[CFG_CRC_BIT];

    // ==========================================================
    // Link domain: reset, enable and preamble settings
    logic       lrst_s1, lrst_s2, lce_s1, lce_s2, lrst_src_reg, lrst_src_next;
    logic [4:0] rst_cnt_reg, rst_cnt_next;
    logic [1:0] lpre_s1, lpre_s2;

    // Quasi-static levels; two flops each
    always_ff @(posedge link_clk)
    begin
        lrst_s1 <= lrst_src_reg;
        lrst_s2 <= lrst_s1;
        lce_s1  <= ce;
        lce_s2  <= lce_s1;
        lpre_s1 <= {cfg_reg[CFG_RPRE_BIT], cfg_reg[CFG_WPRE_BIT]};
        lpre_s2 <= lpre_s1;
    end

    // ==========================================================
    // Link domain: write burst capture
    sdlm_lw_e         lw_st_reg, lw_st_next;
    logic [1:0]       lw_pre_reg, lw_pre_next;
    logic [2:0]       lw_beat_reg, lw_beat_next;
    logic [BW-1:0]    lw_data_reg, lw_data_next;
    logic [FW-1:0]    lw_flag_reg, lw_flag_next;
    logic             lw_crc_reg, lw_crc_next, lw_tog_reg, lw_tog_next;

    always_comb
    begin
        lw_st_next   = lw_st_reg;
        lw_pre_next  = lw_pre_reg;
        lw_beat_next = lw_beat_reg;
        lw_data_next = lw_data_reg;
        lw_flag_next = lw_flag_reg;
        lw_crc_next  = lw_crc_reg;
        lw_tog_next  = lw_tog_reg;
        case (lw_st_reg)
            LW_IDLE:
            begin
                if (link_wr_start)
                begin
                    lw_pre_next = lpre_s2[0] ? PRE_2CK : PRE_1CK;
                    lw_st_next  = LW_PRE;
                end
            end
            LW_PRE:
            begin
                lw_pre_next = lw_pre_reg - 2'h1;
                if (lw_pre_reg == PRE_1CK)
                begin
                    lw_beat_next = 3'h0;
                    lw_st_next   = LW_DATA;
                end
            end
            LW_DATA:
            begin
                lw_data_next[lw_beat_reg*DQW +: DQW]     = link_dq_in;
                lw_flag_next[lw_beat_reg*LANES +: LANES] = link_flag_in;
                lw_beat_next = lw_beat_reg + 3'h1;
                if (lw_beat_reg == LAST_BEAT)
                begin
                    lw_st_next = LW_CRC;
                end
            end
            LW_CRC:
            begin
                lw_crc_next = link_crc_ok;
                lw_tog_next = ~lw_tog_reg;
                lw_st_next  = LW_IDLE;
            end
            default: lw_st_next = LW_IDLE;
        endcase
    end

    always_ff @(posedge link_clk)
    begin
        if (!lrst_s2)
        begin
            lw_st_reg   <= LW_IDLE;
            lw_pre_reg  <= 2'h0;
            lw_beat_reg <= 3'h0;
            lw_data_reg <= '0;
            lw_flag_reg <= '0;
            lw_crc_reg  <= 1'b0;
            lw_tog_reg  <= 1'b0;
        end
        else if (lce_s2)
        begin
            lw_st_reg   <= lw_st_next;
            lw_pre_reg  <= lw_pre_next;
            lw_beat_reg <= lw_beat_next;
            lw_data_reg <= lw_data_next;
            lw_flag_reg <= lw_flag_next;
            lw_crc_reg  <= lw_crc_next;
            lw_tog_reg  <= lw_tog_next;
        end
    end

    // ==========================================================
    // Core domain: lane decode and encode
    logic [BW-1:0] wb_data_reg, wb_data_next, st_data, rd_enc;
    logic [FW-1:0] wb_flag_reg, wb_flag_next, st_keep, rd_fl;

    for (genvar b = 0; b < BEATS; b++)
    begin : g_beat
        for (genvar l = 0; l < LANES; l++)
        begin : g_lane
            sdlm_lane u_lane (
                .wr_byte   (wb_data_reg[(b*LANES+l)*BYTE_W +: BYTE_W]),
                .wr_flag   (wb_flag_reg[b*LANES+l]),
                .mask_en   (mask_eff),
                .wr_inv_en (winv_eff),
                .rd_inv_en (rinv_eff),
                .rd_byte   (rd_data[(b*LANES+l)*BYTE_W +: BYTE_W]),
                .wr_store  (st_data[(b*LANES+l)*BYTE_W +: BYTE_W]),
                .wr_keep   (st_keep[b*LANES+l]),
                .rd_drive  (rd_enc[(b*LANES+l)*BYTE_W +: BYTE_W]),
                .rd_flag   (rd_fl[b*LANES+l])
            );
        end
    end

    // ==========================================================
    // Core domain: commit, read encode and registers
    logic          swt_s1, swt_s2, swt_seen_reg, swt_seen_next;
    logic          wb_crc_reg, wb_crc_next, pend_reg, pend_next;
    logic          we_reg, we_next, drop_reg, drop_next, rd_tog_reg, rd_tog_next;
    logic [BW-1:0] adata_reg, adata_next, rd_dq_reg, rd_dq_next;
    logic [FW-1:0] abe_reg, abe_next, rd_flag_reg, rd_flag_next;
    logic [7:0]    cnt_wr_reg, cnt_wr_next, cnt_fail_reg, cnt_fail_next;
    logic [31:0]   rdata_reg, rdata_next;
    logic          fail;

    always_comb
    begin
        swt_seen_next = swt_s2;
        wb_data_next  = wb_data_reg;
        wb_flag_next  = wb_flag_reg;
        wb_crc_next   = wb_crc_reg;
        pend_next     = 1'b0;
        we_next       = 1'b0;
        adata_next    = adata_reg;
        abe_next      = abe_reg;
        drop_next     = drop_reg;
        cnt_wr_next   = cnt_wr_reg;
        cnt_fail_next = cnt_fail_reg;
        cfg_next      = cfg_reg;
        rd_dq_next    = rd_dq_reg;
        rd_flag_next  = rd_flag_reg;
        rd_tog_next   = rd_tog_reg;
        rdata_next    = 32'h0;
        fail          = crc_en & ~wb_crc_reg;
        rst_cnt_next  = rst_cnt_reg;
        lrst_src_next = lrst_src_reg;
        // Slow link clock must see reset; its toggles are ignored until then
        if (rst_cnt_reg != LRST_HOLD)
        begin
            rst_cnt_next = rst_cnt_reg + 5'h1;
        end
        else
        begin
            lrst_src_next = 1'b1;
        end
        // Link buffer is held steady until the next burst, so one copy is safe
        if (lrst_src_reg && (swt_s2 != swt_seen_reg))
        begin
            wb_data_next = lw_data_reg;
            wb_flag_next = lw_flag_reg;
            wb_crc_next  = lw_crc_reg;
            pend_next    = 1'b1;
        end
        if (pend_reg)
        begin
            drop_next = fail & mask_eff;
            we_next   = ~(fail & mask_eff);
            adata_next = st_data;
            abe_next   = st_keep;
            if (fail)
            begin
                cnt_fail_next = cnt_fail_reg + 8'h1;
            end
            if (!(fail & mask_eff))
            begin
                cnt_wr_next = cnt_wr_reg + 8'h1;
            end
        end
        if (rd_req)
        begin
            rd_dq_next   = rd_enc;
            rd_flag_next = rd_fl;
            rd_tog_next  = ~rd_tog_reg;
        end
        if (reg_wr && (reg_addr == CFG_OFS))
        begin
            cfg_next = reg_wdata[CFG_W-1:0];
        end
        if (reg_rd)
        begin
            case (reg_addr)
                CFG_OFS:  rdata_next = {25'h0, cfg_reg};
                STAT_OFS: rdata_next = {15'h0, drop_reg, cnt_fail_reg, cnt_wr_reg};
                default:  rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            swt_s1       <= 1'b0;
            swt_s2       <= 1'b0;
            swt_seen_reg <= 1'b0;
            wb_data_reg  <= '0;
            wb_flag_reg  <= '0;
            wb_crc_reg   <= 1'b0;
            pend_reg     <= 1'b0;
            we_reg       <= 1'b0;
            adata_reg    <= '0;
            abe_reg      <= '0;
            drop_reg     <= 1'b0;
            cnt_wr_reg   <= CNT_RST;
            cnt_fail_reg <= CNT_RST;
            cfg_reg      <= CFG_RST;
            rd_dq_reg    <= '0;
            rd_flag_reg  <= '0;
            rd_tog_reg   <= 1'b0;
            rdata_reg    <= 32'h0;
            rst_cnt_reg  <= 5'h0;
            lrst_src_reg <= 1'b0;
        end
        else if (ce)
        begin
            swt_s1       <= lw_tog_reg;
            swt_s2       <= swt_s1;
            swt_seen_reg <= swt_seen_next;
            wb_data_reg  <= wb_data_next;
            wb_flag_reg  <= wb_flag_next;
            wb_crc_reg   <= wb_crc_next;
            pend_reg     <= pend_next;
            we_reg       <= we_next;
            adata_reg    <= adata_next;
            abe_reg      <= abe_next;
            drop_reg     <= drop_next;
            cnt_wr_reg   <= cnt_wr_next;
            cnt_fail_reg <= cnt_fail_next;
            cfg_reg      <= cfg_next;
            rd_dq_reg    <= rd_dq_next;
            rd_flag_reg  <= rd_flag_next;
            rd_tog_reg   <= rd_tog_next;
            rdata_reg    <= rdata_next;
            rst_cnt_reg  <= rst_cnt_next;
            lrst_src_reg <= lrst_src_next;
        end
    end

    assign array_we   = we_reg;
    assign array_data = adata_reg;
    assign array_be   = abe_reg;
    assign reg_rdata  = rdata_reg;

    // ==========================================================
    // Link domain: read burst drive
    sdlm_lr_e          lr_st_reg, lr_st_next;
    logic [1:0]        lr_pre_reg, lr_pre_next;
    logic [2:0]        lr_beat_reg, lr_beat_next;
    logic              lrt_s1, lrt_s2, lrt_seen_reg, lrt_seen_next;
    logic [DQW-1:0]    ldq_reg, ldq_next;
    logic [LANES-1:0]  lfl_reg, lfl_next;
    logic              loe_reg, loe_next;

    always_comb
    begin
        lr_st_next    = lr_st_reg;
        lr_pre_next   = lr_pre_reg;
        lr_beat_next  = lr_beat_reg;
        lrt_seen_next = lrt_seen_reg;
        ldq_next      = ldq_reg;
        lfl_next      = lfl_reg;
        loe_next      = 1'b0;
        case (lr_st_reg)
            LR_IDLE:
            begin
                if (lrt_s2 != lrt_seen_reg)
                begin
                    lrt_seen_next = lrt_s2;
                    lr_pre_next   = lpre_s2[1] ? PRE_2CK : PRE_1CK;
                    lr_st_next    = LR_PRE;
                end
            end
            LR_PRE:
            begin
                lr_pre_next = lr_pre_reg - 2'h1;
                if (lr_pre_reg == PRE_1CK)
                begin
                    lr_beat_next = 3'h0;
                    lr_st_next   = LR_DATA;
                end
            end
            LR_DATA:
            begin
                ldq_next     = rd_dq_reg[lr_beat_reg*DQW +: DQW];
                lfl_next     = rd_flag_reg[lr_beat_reg*LANES +: LANES];
                loe_next     = 1'b1;
                lr_beat_next = lr_beat_reg + 3'h1;
                if (lr_beat_reg == LAST_BEAT)
                begin
                    lr_st_next = LR_IDLE;
                end
            end
            default: lr_st_next = LR_IDLE;
        endcase
    end

    always_ff @(posedge link_clk)
    begin
        if (!lrst_s2)
        begin
            lr_st_reg    <= LR_IDLE;
            lr_pre_reg   <= 2'h0;
            lr_beat_reg  <= 3'h0;
            lrt_s1       <= 1'b0;
            lrt_s2       <= 1'b0;
            lrt_seen_reg <= 1'b0;
            ldq_reg      <= '0;
            lfl_reg      <= '0;
            loe_reg      <= 1'b0;
        end
        else if (lce_s2)
        begin
            lr_st_reg    <= lr_st_next;
            lr_pre_reg   <= lr_pre_next;
            lr_beat_reg  <= lr_beat_next;
            lrt_s1       <= rd_tog_reg;
            lrt_s2       <= lrt_s1;
            lrt_seen_reg <= lrt_seen_next;
            ldq_reg      <= ldq_next;
            lfl_reg      <= lfl_next;
            loe_reg      <= loe_next;
        end
    end

    assign link_dq_out   = ldq_reg;
    assign link_flag_out = lfl_reg;
    assign link_dq_oe    = loe_reg;
    assign link_flag_oe  = loe_reg;

    // ==========================================================
    // Checks on the core domain
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_wr_inv_low: assert property (we_reg && winv_eff && !wb_flag_reg[0]
        |-> adata_reg[7:0] == ~wb_data_reg[7:0]) else $error("low flag byte not inverted");
    a_wr_inv_high: assert property (we_reg && winv_eff && wb_flag_reg[0]
        |-> adata_reg[7:0] == wb_data_reg[7:0]) else $error("high flag byte altered");
    a_rd_inv_many: assert property (ce && rd_req && rinv_eff
        && ($countones(~rd_data[7:0]) > 4)
        |=> !rd_flag_reg[0] && rd_dq_reg[7:0] == ~$past(rd_data[7:0]))
        else $error("read byte with many zeros not inverted");
    a_rd_inv_few: assert property (ce && rd_req && ($countones(~rd_data[7:0]) <= 4)
        |=> rd_flag_reg[0] && rd_dq_reg[7:0] == $past(rd_data[7:0]))
        else $error("read byte with few zeros changed");
    a_narrow_no_inv: assert property (ce && rd_req && !WIDE
        |=> rd_flag_reg == '1) else $error("narrow part inverted read");
    a_mask_drop: assert property (we_reg && mask_eff && !wb_flag_reg[0]
        |-> !abe_reg[0]) else $error("masked byte enabled");
    a_crc_persist: assert property (ce && pend_reg && mask_eff && fail
        |=> !we_reg ##1 !we_reg) else $error("failed burst written with mask on");
    a_crc_nonpersist: assert property (ce && pend_reg && !mask_eff && !winv_eff && fail
        |=> we_reg && abe_reg == '1) else $error("burst not written with mask off");
    a_plain_store: assert property (we_reg && !mask_eff && !winv_eff
        |-> abe_reg == '1 && adata_reg == wb_data_reg) else $error("plain byte altered");

endmodule

//--- dv/sdlm_ctrl_model.sv
/*
 * Controller-side model: drives one write burst on the link pins per toggle of go.
 * Assumes the bench sets pre, dq, fl and crc before it toggles go.
 */
`timescale 1ns/10ps
module sdlm_ctrl_model (
    input  wire logic         link_clk,      // Link clock
    input  wire logic         go,            // Toggle starts a burst
    input  wire logic [1:0]   pre,           // Write preamble clocks
    input  wire logic [127:0] dq,            // Burst data, beat 0 lowest
    input  wire logic [15:0]  fl,            // Lane pins, bit b*2+l
    input  wire logic         crc,           // Check result to send
    output logic              link_wr_start, // Burst start
    output logic      [15:0]  link_dq_in,    // Data pins
    output logic      [1:0]   link_flag_in,  // Lane pins
    output logic              link_crc_ok    // Check result
);
    int b;
    initial
    begin
        link_wr_start = 1'b0;
        link_dq_in    = 16'h0000;
        link_flag_in  = 2'h3;
        link_crc_ok   = 1'b0;
    end
    // ==========================================================
    // Burst sequence; the bench keeps bursts far apart
    always
    begin
        @(go);
        @(posedge link_clk);
        link_wr_start <= 1'b1;
        @(posedge link_clk);
        link_wr_start <= 1'b0;
        repeat (pre) @(posedge link_clk);
        for (b = 0; b < 8; b++)
        begin
            link_dq_in   <= dq[b*16+:16];
            link_flag_in <= fl[b*2+:2];
            @(posedge link_clk);
        end
        // Released pins must not keep looking like valid data
        link_dq_in   <= ~link_dq_in;
        link_flag_in <= ~link_flag_in;
        link_crc_ok  <= crc;
        @(posedge link_clk);
        link_crc_ok  <= ~crc;
    end
endmodule

//--- dv/sdlm_top_tb_top.sv
/*
 * Self-checking bench for the byte-lane data path, sixteen-bit part.
 * Assumes the controller model in sdlm_ctrl_model.sv.
 */
`timescale 1ns/10ps
module sdlm_top_tb_top;
    import sdlm_pkg::*;
    logic sys_clk, rst_b, ce, reg_wr, reg_rd, link_clk, link_wr_start, link_crc_ok, rd_req;
    logic go = 1'b0;
    logic crc, link_dq_oe, link_flag_oe, array_we;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, r;
    logic [15:0] link_dq_in, link_dq_out, array_be, fl;
    logic [1:0] link_flag_in, link_flag_out, pre;
    logic [127:0] rd_data, array_data, dq;
    int err_count, checked;
    sdlm_top sdlm_top_i (.*);
    sdlm_ctrl_model sdlm_ctrl_model_i (.*);
    initial
    begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wburst(input logic [6:0] c, input logic [15:0] f, input logic ok, input logic we);
        int n;
        logic [127:0] ed, m;
        wr_reg(CFG_OFS, {25'h0, c});
        // Preamble setting needs a few link clocks to reach the link side
        repeat (25) @(posedge sys_clk);
        fl = f;
        crc = ok;
        pre = c[CFG_WPRE_BIT] ? PRE_2CK : PRE_1CK;
        for (int i = 0; i < 16; i++)
        begin
            m[i*8+:8] = {8{c[CFG_MASK_BIT] ? f[i] : 1'b1}};
            ed[i*8+:8] = (c[CFG_WINV_BIT] && !c[CFG_MASK_BIT] && !f[i]) ? ~dq[i*8+:8] : dq[i*8+:8];
        end
        go = ~go;
        n = 0;
        while (array_we !== 1'b1 && n < 150)
        begin
            @(posedge sys_clk);
            #1 n++;
        end
        chk(array_we, we);
        if (we)
        begin
            chk(array_be, {m[120], m[112], m[104], m[96], m[88], m[80], m[72], m[64],
                           m[56], m[48], m[40], m[32], m[24], m[16], m[8], m[0]});
            chk(array_data & m, ed & m);
        end
        repeat (40) @(posedge sys_clk);
        $display("burst cfg=%h done", c);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_regs;
        rd_reg(CFG_OFS, r);
        chk(r, {25'h0, CFG_RST});
        wr_reg(8'h08, 32'hffffffff);
        rd_reg(8'h08, r);
        chk(r, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_read;
        int n;
        logic [7:0] x;
        logic inv;
        wr_reg(CFG_OFS, 32'h44);
        @(posedge sys_clk);
        rd_req <= 1'b1;
        rd_data <= 128'h0f07_00ff_f0e0_1f3f_8001_7e81_0f07_5aa5;
        @(posedge sys_clk);
        rd_req <= 1'b0;
        n = 0;
        while (link_dq_oe !== 1'b1 && n < 40)
        begin
            @(negedge link_clk);
            n++;
        end
        for (int i = 0; i < 16; i++)
        begin
            x = rd_data[i*8+:8];
            inv = $countones(~x) > ZERO_LIMIT;
            chk({link_flag_oe, link_dq_out[(i%2)*8+:8], link_flag_out[i%2]}, {1'b1, inv ? ~x : x, ~inv});
            if (i % 2 == 1)
                @(negedge link_clk);
        end
        chk(link_dq_oe, 1'b0);
        $display("test read done");
    endtask
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial
    begin
        {rst_b, reg_wr, reg_rd, rd_req, go, crc} = '0;
        {reg_addr, reg_wdata, rd_data, fl, pre} = '0;
        ce = 1'b1;
        dq = 128'h17e8_c3a0_0ff0_5a96_8421_e07f_3c01_fe10;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (60) @(posedge sys_clk);
        t_regs;
        wburst(7'h02, 16'h5a3c, 1'b1, 1'b1);
        wburst(7'h22, 16'hc3a5, 1'b1, 1'b1);
        wburst(7'h11, 16'h0ff0, 1'b0, 1'b0);
        wburst(7'h11, 16'h36c9, 1'b1, 1'b1);
        wburst(7'h10, 16'h0f0f, 1'b0, 1'b1);
        rd_reg(STAT_OFS, r);
        chk(r, 32'h0000_0204);
        t_read;
        end_sim;
    end
    initial
    begin
        #30000;
        err_count++;
        end_sim;
    end
endmodule
